// *** logic/vmdac_pkg.sv ***
// Constants, field layout and types for the second monitor output configuration block
package vmdac_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned VMDAC_CTRL_INDEX = 'hF6;
    localparam int unsigned VMDAC_STAT_INDEX = 'hF8;
    localparam int unsigned VMDAC_ADDR_W = 12;
    localparam logic [VMDAC_ADDR_W-1:0] VMDAC_CTRL_ADDR = VMDAC_ADDR_W'(VMDAC_CTRL_INDEX * 4);
    localparam logic [VMDAC_ADDR_W-1:0] VMDAC_STAT_ADDR = VMDAC_ADDR_W'(VMDAC_STAT_INDEX * 4);
    localparam int unsigned VMDAC_DATA_W = 32;
    localparam int unsigned VMDAC_BE_W = VMDAC_DATA_W / 8;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int unsigned VMDAC_EXP_LSB = 19;
    localparam int unsigned VMDAC_EXP_W = 4;
    localparam int unsigned VMDAC_FRAC_LSB = 15;
    localparam int unsigned VMDAC_FRAC_W = 4;
    localparam int unsigned VMDAC_POL_BIT = 14;
    localparam int unsigned VMDAC_PTR_LSB = 0;
    localparam int unsigned VMDAC_PTR_W = 14;
    localparam logic [VMDAC_EXP_W-1:0] VMDAC_EXP_RST = 4'h0;
    localparam logic [VMDAC_FRAC_W-1:0] VMDAC_FRAC_RST = 4'h8;
    localparam logic VMDAC_POL_RST = 1'h0;
    localparam logic [VMDAC_PTR_W-1:0] VMDAC_PTR_RST = 14'h0000;

    // ************************************************************
    // Status register fields
    // ************************************************************
    localparam int unsigned VMDAC_STAT_CODE_LSB = 0;
    localparam int unsigned VMDAC_STAT_BUSY_BIT = 16;

    // ************************************************************
    // Arithmetic
    // ************************************************************
    localparam int unsigned VMDAC_VAR_W = 32;
    localparam int unsigned VMDAC_WIDE_W = 48;
    localparam int unsigned VMDAC_CODE_W = 12;
    localparam int unsigned VMDAC_PU_SHIFT = 24;
    localparam int unsigned VMDAC_FRAC_SHIFT = 3;
    localparam logic [VMDAC_CODE_W-1:0] VMDAC_CODE_MAX = 12'hFFF;
    localparam logic [VMDAC_CODE_W-1:0] VMDAC_CODE_RST = 12'h000;
    localparam logic signed [VMDAC_WIDE_W-1:0] VMDAC_ONE_PU = VMDAC_WIDE_W'(1) <<< VMDAC_PU_SHIFT;

    typedef struct packed {
        logic [VMDAC_EXP_W-1:0] exp_gain;
        logic [VMDAC_FRAC_W-1:0] frac_gain;
        logic polarity;
        logic [VMDAC_PTR_W-1:0] pointer;
    } vmdac_cfg_t;

    typedef enum logic [1:0] {
        VMDAC_ST_IDLE = 2'h0,
        VMDAC_ST_WAIT = 2'h1,
        VMDAC_ST_SCALE = 2'h3,
        VMDAC_ST_LOAD = 2'h2
    } vmdac_state_t;

endpackage

// *** logic/vmdac_scaler.sv ***
// Gain, polarity mapping and saturation of one monitored sample
`timescale 1ns/100ps
module vmdac_scaler
    import vmdac_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic start_in,
    input wire logic signed [VMDAC_VAR_W-1:0] var_in,
    input wire vmdac_cfg_t cfg_in,
    output logic [VMDAC_CODE_W-1:0] code_out,
    output logic done_out
);

    // ************************************************************
    // Saturation to the converter range
    // ************************************************************
    function automatic logic [VMDAC_CODE_W-1:0] vmdac_sat(input logic signed [VMDAC_WIDE_W-1:0] v);
        logic signed [VMDAC_WIDE_W-1:0] lim;
        lim = $signed(VMDAC_WIDE_W'(VMDAC_CODE_MAX));
        if (v < 0)
            return '0;
        else if (v > lim)
            return VMDAC_CODE_MAX;
        else
            return v[VMDAC_CODE_W-1:0];
    endfunction

    logic signed [VMDAC_WIDE_W-1:0] wide;
    logic signed [VMDAC_WIDE_W-1:0] scaled;
    logic [VMDAC_CODE_W-1:0] next_code;

    // ************************************************************
    // Scaling
    // ************************************************************
    always_comb
    begin
        wide = VMDAC_WIDE_W'(var_in);
        if (cfg_in.frac_gain != '0)
            scaled = (wide * $signed({1'b0, cfg_in.frac_gain})) >>> VMDAC_FRAC_SHIFT;
        else
            scaled = wide <<< cfg_in.exp_gain;
        // 3 V full scale is reached at one per-unit in both mappings
        if (cfg_in.polarity)
            next_code = vmdac_sat(scaled >>> (VMDAC_PU_SHIFT - VMDAC_CODE_W));
        else
            next_code = vmdac_sat((scaled + VMDAC_ONE_PU) >>> (VMDAC_PU_SHIFT - VMDAC_CODE_W + 1));
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            code_out <= VMDAC_CODE_RST;
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= start_in;
            if (start_in)
                code_out <= next_code;
        end
    end

endmodule

// *** logic/vmdac_top.sv ***
// Second monitor output configuration: register slave, variable fetch loop and converter code
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
module vmdac_top
    import vmdac_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [VMDAC_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [VMDAC_DATA_W-1:0] avs_writedata_in,
    input wire logic [VMDAC_BE_W-1:0] avs_byteenable_in,
    output logic [VMDAC_DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [VMDAC_PTR_W-1:0] var_addr_out,
    output logic var_req_out,
    input wire logic [VMDAC_VAR_W-1:0] var_data_in,
    input wire logic var_valid_in,
    output logic [VMDAC_CODE_W-1:0] dac_code_out,
    output logic dac_update_out
);

    // ************************************************************
    // Register image helpers
    // ************************************************************
    function automatic logic [VMDAC_DATA_W-1:0] vmdac_pack(input vmdac_cfg_t c);
        logic [VMDAC_DATA_W-1:0] w;
        w = '0;
        w[VMDAC_EXP_LSB +: VMDAC_EXP_W] = c.exp_gain;
        w[VMDAC_FRAC_LSB +: VMDAC_FRAC_W] = c.frac_gain;
        w[VMDAC_POL_BIT] = c.polarity;
        w[VMDAC_PTR_LSB +: VMDAC_PTR_W] = c.pointer;
        return w;
    endfunction

    function automatic vmdac_cfg_t vmdac_unpack(input logic [VMDAC_DATA_W-1:0] w);
        vmdac_cfg_t c;
        c.exp_gain = w[VMDAC_EXP_LSB +: VMDAC_EXP_W];
        c.frac_gain = w[VMDAC_FRAC_LSB +: VMDAC_FRAC_W];
        c.polarity = w[VMDAC_POL_BIT];
        c.pointer = w[VMDAC_PTR_LSB +: VMDAC_PTR_W];
        return c;
    endfunction

    function automatic logic [VMDAC_DATA_W-1:0] vmdac_merge(input logic [VMDAC_DATA_W-1:0] old_w,
                                                           input logic [VMDAC_DATA_W-1:0] new_w,
                                                           input logic [VMDAC_BE_W-1:0] be);
        logic [VMDAC_DATA_W-1:0] m;
        m = old_w;
        for (int i = 0; i < VMDAC_BE_W; i++)
        begin
            if (be[i])
                m[i*8 +: 8] = new_w[i*8 +: 8];
        end
        return m;
    endfunction

    vmdac_cfg_t cfg;
    vmdac_state_t state;
    logic signed [VMDAC_VAR_W-1:0] sample;
    logic scale_start;
    logic [VMDAC_CODE_W-1:0] scaled_code;
    logic scaled_done;
    logic bus_req;
    logic bus_accept;
    logic [VMDAC_DATA_W-1:0] next_readdata;

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************
    // One wait state on every access: waitrequest drops for exactly one cycle
    assign bus_req = avs_read_in || avs_write_in;
    assign bus_accept = bus_req && !avs_waitrequest_out;

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            avs_waitrequest_out <= 1'b1;
        else
            avs_waitrequest_out <= !(bus_req && avs_waitrequest_out);
    end

    always_comb
    begin
        next_readdata = '0;
        case (avs_address_in)
            // Gain and polarity fields are write-only and read as zero
            VMDAC_CTRL_ADDR: next_readdata[VMDAC_PTR_LSB +: VMDAC_PTR_W] = cfg.pointer;
            VMDAC_STAT_ADDR:
            begin
                next_readdata[VMDAC_STAT_CODE_LSB +: VMDAC_CODE_W] = dac_code_out;
                next_readdata[VMDAC_STAT_BUSY_BIT] = var_req_out;
            end
            default: next_readdata = '0;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            avs_readdata_out <= '0;
        else if (avs_read_in && avs_waitrequest_out)
            avs_readdata_out <= next_readdata;
    end

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cfg.exp_gain <= VMDAC_EXP_RST;
            cfg.frac_gain <= VMDAC_FRAC_RST;
            cfg.polarity <= VMDAC_POL_RST;
            cfg.pointer <= VMDAC_PTR_RST;
        end
        else if (bus_accept && avs_write_in && avs_address_in == VMDAC_CTRL_ADDR)
            cfg <= vmdac_unpack(vmdac_merge(vmdac_pack(cfg), avs_writedata_in, avs_byteenable_in));
    end

    // ************************************************************
    // Refresh loop
    // ************************************************************
    // Gain changes take effect on the next sample; no software kick is needed
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state <= VMDAC_ST_IDLE;
            var_req_out <= 1'b0;
            var_addr_out <= VMDAC_PTR_RST;
            sample <= '0;
        end
        else
        begin
            case (state)
                VMDAC_ST_IDLE:
                begin
                    var_req_out <= 1'b1;
                    var_addr_out <= cfg.pointer;
                    state <= VMDAC_ST_WAIT;
                end
                VMDAC_ST_WAIT:
                begin
                    // A fetch that never answers stalls the output at its last code
                    if (var_valid_in)
                    begin
                        var_req_out <= 1'b0;
                        sample <= $signed(var_data_in);
                        state <= VMDAC_ST_SCALE;
                    end
                end
                VMDAC_ST_SCALE: state <= VMDAC_ST_LOAD;
                VMDAC_ST_LOAD:
                begin
                    if (scaled_done)
                        state <= VMDAC_ST_IDLE;
                end
                default: state <= VMDAC_ST_IDLE;
            endcase
        end
    end

    assign scale_start = (state == VMDAC_ST_SCALE);

    vmdac_scaler u_scaler (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .start_in(scale_start),
        .var_in(sample),
        .cfg_in(cfg),
        .code_out(scaled_code),
        .done_out(scaled_done)
    );

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            dac_code_out <= VMDAC_CODE_RST;
            dac_update_out <= 1'b0;
        end
        else
        begin
            dac_update_out <= (state == VMDAC_ST_LOAD) && scaled_done;
            if ((state == VMDAC_ST_LOAD) && scaled_done)
                dac_code_out <= scaled_code;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    logic cfg_written;
    logic signed [VMDAC_WIDE_W-1:0] chk_wide;

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            cfg_written <= 1'b0;
        else if (bus_accept && avs_write_in && avs_address_in == VMDAC_CTRL_ADDR)
            cfg_written <= 1'b1;
    end

    assign chk_wide = VMDAC_WIDE_W'(sample);

    sequence s_fetch_answered;
        var_req_out && var_valid_in;
    endsequence

    sequence s_code_loaded;
        ##3 dac_update_out ##1 var_req_out;
    endsequence

    a_reset_defaults: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !cfg_written |-> cfg.frac_gain == VMDAC_FRAC_RST && cfg.polarity == VMDAC_POL_RST
        && cfg.pointer == VMDAC_PTR_RST)
        else $error("control fields left their reset values without a write");

    a_pointer_write: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        bus_accept && avs_write_in && avs_address_in == VMDAC_CTRL_ADDR && avs_byteenable_in == 4'hF
        |=> cfg.pointer == $past(avs_writedata_in[VMDAC_PTR_W-1:0]))
        else $error("pointer write not stored");

    a_pointer_fetch: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        $rose(var_req_out) |-> var_addr_out == $past(cfg.pointer))
        else $error("fetch address differs from pointer");

    a_refresh_loop: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        s_fetch_answered |-> s_code_loaded)
        else $error("sample not turned into a converter update in time");

    a_unity_gain: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        scale_start && cfg.frac_gain == VMDAC_FRAC_RST && cfg.polarity && chk_wide >= 0
        && chk_wide < VMDAC_ONE_PU
        |=> scaled_code == $past(chk_wide[VMDAC_PU_SHIFT-1 -: VMDAC_CODE_W])
        ##1 dac_code_out == $past(scaled_code))
        else $error("unity fraction gain gives wrong code");

    a_exp_double: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        scale_start && cfg.frac_gain == '0 && cfg.exp_gain == 4'h1 && cfg.polarity && chk_wide >= 0
        && chk_wide < (VMDAC_ONE_PU >>> 1)
        |=> scaled_code == $past(chk_wide[VMDAC_PU_SHIFT-2 -: VMDAC_CODE_W]))
        else $error("exponent gain of one does not double");

    a_exp_unity: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        scale_start && cfg.frac_gain == '0 && cfg.exp_gain == '0 && cfg.polarity && chk_wide >= 0
        && chk_wide < VMDAC_ONE_PU
        |=> scaled_code == $past(chk_wide[VMDAC_PU_SHIFT-1 -: VMDAC_CODE_W]))
        else $error("exponent mode with zero exponent is not unity");

    a_unipolar_clamp: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        scale_start && cfg.polarity && chk_wide < 0 |=> scaled_code == '0)
        else $error("negative value not clamped to 0 V");

    a_bipolar_mid: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        scale_start && !cfg.polarity && chk_wide == 0 |=> scaled_code == ~(VMDAC_CODE_MAX >> 1))
        else $error("bipolar zero is not mid scale");

    a_full_scale: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        scale_start && cfg.frac_gain == VMDAC_FRAC_RST && chk_wide >= VMDAC_ONE_PU
        |=> scaled_code == VMDAC_CODE_MAX)
        else $error("one per-unit does not reach 3 V");

    a_bus_answer: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        bus_req && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus access not answered after one wait state");

    a_fetch_hold: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        var_req_out && !var_valid_in |=> var_req_out && $stable(var_addr_out))
        else $error("fetch request or address moved before the answer");

    a_update_pulse: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        dac_update_out |=> !dac_update_out)
        else $error("converter update strobe longer than one cycle");

    a_code_hold: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !dac_update_out |-> $stable(dac_code_out))
        else $error("converter code changed without an update strobe");

    // Write-only gain and polarity bits must never leak into a read
    a_readback_ctrl: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        avs_read_in && avs_waitrequest_out && avs_address_in == VMDAC_CTRL_ADDR
        |=> avs_readdata_out[VMDAC_DATA_W-1:VMDAC_PTR_W] == '0
        && avs_readdata_out[VMDAC_PTR_W-1:0] == $past(cfg.pointer))
        else $error("control read does not show just the pointer");

    a_status_read: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        avs_read_in && avs_waitrequest_out && avs_address_in == VMDAC_STAT_ADDR
        |=> avs_readdata_out[VMDAC_STAT_BUSY_BIT] == $past(var_req_out)
        && avs_readdata_out[VMDAC_STAT_CODE_LSB +: VMDAC_CODE_W] == $past(dac_code_out))
        else $error("status read does not show code and pending fetch");

    a_frac_half: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        scale_start && cfg.frac_gain == 4'h4 && cfg.polarity && chk_wide >= 0
        && chk_wide < VMDAC_ONE_PU
        |=> scaled_code == $past(chk_wide[VMDAC_PU_SHIFT -: VMDAC_CODE_W]))
        else $error("fraction gain of four eighths does not halve");

    a_bipolar_floor: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        scale_start && !cfg.polarity && cfg.frac_gain == VMDAC_FRAC_RST && chk_wide <= -VMDAC_ONE_PU
        |=> scaled_code == '0)
        else $error("minus one per-unit does not reach 0 V");

endmodule

// *** verif/test_variable_monitor_dac_config.sv ***
// Self-checking bench for the second monitor output configuration block
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module test_variable_monitor_dac_config
    import vmdac_pkg::*;
;
    logic core_clk_in;
    logic arst_n_in;
    logic [VMDAC_ADDR_W-1:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [VMDAC_DATA_W-1:0] avs_writedata_in;
    logic [VMDAC_BE_W-1:0] avs_byteenable_in;
    logic [VMDAC_DATA_W-1:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [VMDAC_PTR_W-1:0] var_addr_out;
    logic var_req_out;
    logic [VMDAC_VAR_W-1:0] var_data_in;
    logic var_valid_in;
    logic [VMDAC_CODE_W-1:0] dac_code_out;
    logic dac_update_out;
    int err_count;
    int checks_done;
    int cycles;
    int seed;
    logic [13:0] cfg_ptr;
    logic [13:0] req_ptr;
    logic [11:0] last_code;
    logic [31:0] rd;

    vmdac_top DUT (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .var_addr_out(var_addr_out),
        .var_req_out(var_req_out),
        .var_data_in(var_data_in),
        .var_valid_in(var_valid_in),
        .dac_code_out(dac_code_out),
        .dac_update_out(dac_update_out)
    );

    // ************************************************************
    // Clock, timeout and verdict
    // ************************************************************
    initial
    begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end

    // The whole run needs about a thousand cycles; the ceiling leaves a wide margin
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            results();
        end
    end

    task automatic results();
        if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ************************************************************
    // Expected converter code
    // ************************************************************
    function automatic logic [11:0] exp_code(input logic signed [31:0] v, input logic [3:0] fr,
                                             input logic [3:0] ex, input logic pol);
        logic signed [47:0] s;
        s = 48'(v);
        if (fr != 4'h0)
            s = (s * $signed({1'b0, fr})) >>> 3;
        else
            s = s <<< ex;
        if (pol)
            s = s >>> 12;
        else
            s = (s + 48'sh000001000000) >>> 13;
        if (s < 0)
            return 12'h000;
        if (s > 48'sh000000000FFF)
            return 12'hFFF;
        return s[11:0];
    endfunction

    // ************************************************************
    // Bus and fetch tasks, all entered just after a rising edge
    // ************************************************************
    task automatic wait_ack();
        do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        avs_write_in <= 1'b1;
        wait_ack();
        avs_write_in <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
        avs_address_in <= a;
        avs_read_in <= 1'b1;
        wait_ack();
        d = avs_readdata_out;
        avs_read_in <= 1'b0;
        @(posedge core_clk_in);
    endtask

    // Answers one pending fetch; data is inverted once released so stale values never match
    task automatic sample(input logic signed [31:0] v);
        int n;
        while (var_req_out !== 1'b1)
            @(posedge core_clk_in);
        `CHK(var_addr_out, req_ptr)
        var_data_in <= v;
        var_valid_in <= 1'b1;
        @(posedge core_clk_in);
        var_valid_in <= 1'b0;
        var_data_in <= ~v;
        n = 0;
        do
        begin
            @(posedge core_clk_in);
            n++;
        end while (dac_update_out !== 1'b1);
        `CHK(n, 3)
        last_code = dac_code_out;
        req_ptr = cfg_ptr;
        @(posedge core_clk_in);
        `CHK(dac_update_out, 1'b0)
    endtask

    task automatic run(input logic signed [31:0] v, input logic [3:0] fr, input logic [3:0] ex,
                       input logic pol, input logic [13:0] ptr);
        bus_wr(VMDAC_CTRL_ADDR, {9'h000, ex, fr, pol, ptr}, 4'hF);
        cfg_ptr = ptr;
        sample(v);
        `CHK(last_code, exp_code(v, fr, ex, pol))
        bus_rd(VMDAC_CTRL_ADDR, rd);
        `CHK(rd, {18'h00000, ptr})
        bus_rd(VMDAC_STAT_ADDR, rd);
        `CHK(rd[11:0], last_code)
        `CHK(rd[16], 1'b1)
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        arst_n_in = 1'b0;
        avs_address_in = 12'h000;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h00000000;
        avs_byteenable_in = 4'h0;
        var_data_in = 32'h00000000;
        var_valid_in = 1'b0;
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        seed = 88;
        cfg_ptr = 14'h0000;
        req_ptr = 14'h0000;
        repeat (4) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        @(posedge core_clk_in);
        // Reset configuration: unity gain, bipolar, pointer zero
        sample(32'sh00800000);
        `CHK(last_code, 12'hC00)
        sample(32'sh00000000);
        `CHK(last_code, 12'h800)
        bus_rd(VMDAC_CTRL_ADDR, rd);
        `CHK(rd, 32'h00000000)
        // Saturation, exponent mode and gain corners
        run(32'sh04000000, 4'h8, 4'h0, 1'b0, 14'h3FFF);
        run(32'shFE000000, 4'h8, 4'h0, 1'b0, 14'h0001);
        run(32'shFF800000, 4'h8, 4'h0, 1'b1, 14'h2AAA);
        run(32'sh01000000, 4'h8, 4'h0, 1'b1, 14'h1555);
        run(32'sh00000100, 4'h0, 4'hF, 1'b0, 14'h0100);
        run(32'sh00000100, 4'h0, 4'h0, 1'b1, 14'h0200);
        run(32'sh00800000, 4'hF, 4'h7, 1'b0, 14'h0300);
        run(32'sh00800000, 4'h1, 4'h7, 1'b1, 14'h0400);
        run(32'sh00400000, 4'h8, 4'h0, 1'b1, 14'h0500);
        run(32'sh00200000, 4'h0, 4'h1, 1'b1, 14'h0600);
        run(32'sh00800000, 4'h4, 4'h3, 1'b1, 14'h0700);
        // Every fraction code, then free random traffic
        for (int f = 0; f < 16; f++)
            run($random(seed) >>> 6, 4'(f), 4'($random(seed)), 1'($random(seed)), 14'($random(seed)));
        repeat (30)
            run($random(seed) >>> 6, 4'($random(seed)), 4'($random(seed)), 1'($random(seed)),
                14'($random(seed)));
        // Byte enables touch only the selected byte of the pointer
        bus_wr(VMDAC_CTRL_ADDR, {9'h000, 4'h0, 4'h8, 1'b0, 14'h3FFF}, 4'hF);
        bus_wr(VMDAC_CTRL_ADDR, 32'h00000000, 4'h1);
        bus_rd(VMDAC_CTRL_ADDR, rd);
        `CHK(rd, 32'h00003F00)
        // Unmapped place reads zero and ignores writes
        bus_wr(12'h100, 32'hFFFFFFFF, 4'hF);
        bus_rd(12'h100, rd);
        `CHK(rd, 32'h00000000)
        bus_rd(VMDAC_CTRL_ADDR, rd);
        `CHK(rd, 32'h00003F00)
        cfg_ptr = 14'h3F00;
        sample(32'sh00400000);
        `CHK(last_code, 12'hA00)
        sample(32'sh00000000);
        `CHK(last_code, 12'h800)
        // Reset in mid-run brings back unity gain, bipolar output and pointer zero
        bus_wr(VMDAC_CTRL_ADDR, {9'h000, 4'h5, 4'h3, 1'b1, 14'h1234}, 4'hF);
        arst_n_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        `CHK(dac_code_out, 12'h000)
        arst_n_in <= 1'b1;
        cfg_ptr = 14'h0000;
        req_ptr = 14'h0000;
        @(posedge core_clk_in);
        sample(32'sh00800000);
        `CHK(last_code, 12'hC00)
        bus_rd(VMDAC_CTRL_ADDR, rd);
        `CHK(rd, 32'h00000000)
        results();
    end
endmodule
